// [rtl/imflr_pkg.sv]
// imflr_pkg: register map, field layout and reset values of the interrupt mask / fifo level / rx config bank
package imflr_pkg;
	// register byte offsets
	localparam logic [7:0] IMFLR_OFF_MASK = 8'h5c;
	localparam logic [7:0] IMFLR_OFF_PROBE = 8'h64;
	localparam logic [7:0] IMFLR_OFF_LEVEL = 8'h68;
	localparam logic [7:0] IMFLR_OFF_RXCFG = 8'h6c;
	// constant pattern of the byte order probe
	localparam logic [31:0] IMFLR_PROBE_VALUE = 32'h87654321;
	// writable bits of the interrupt mask register
	localparam logic [31:0] IMFLR_MASK_WMASK = 32'h83bfe7df;
	// interrupt flag positions used here
	localparam int IMFLR_BIT_RXDMA = 20;
	localparam int IMFLR_BIT_TXAVAIL = 9;
	localparam int IMFLR_BIT_TXSLVL = 7;
	localparam int IMFLR_BIT_RXSLVL = 3;
	// fifo level threshold fields and reset values
	localparam logic [7:0] IMFLR_TXAVAIL_RST = 8'h48;
	localparam logic [7:0] IMFLR_TXSLVL_RST = 8'h00;
	localparam logic [7:0] IMFLR_RXSLVL_RST = 8'h00;
	localparam int IMFLR_TXAVAIL_LSB = 24;
	localparam int IMFLR_TXSLVL_LSB = 16;
	localparam int IMFLR_RXSLVL_LSB = 0;
	// receive configuration fields
	localparam int IMFLR_ALIGN_LSB = 30;
	localparam int IMFLR_COUNT_LSB = 16;
	localparam int IMFLR_FLUSH_BIT = 15;
	localparam int IMFLR_OFFSET_LSB = 8;
	localparam logic [1:0] IMFLR_ALIGN_RST = 2'h0;
	localparam logic [11:0] IMFLR_COUNT_RST = 12'h000;
	localparam logic [4:0] IMFLR_OFFSET_RST = 5'h00;
	localparam logic [11:0] IMFLR_COUNT_ONE = 12'h001;
	localparam logic [11:0] IMFLR_COUNT_ZERO = 12'h000;
	// end alignment encodings
	typedef enum logic [1:0] {
		IMFLR_ALIGN_4 = 2'h0,
		IMFLR_ALIGN_16 = 2'h1,
		IMFLR_ALIGN_32 = 2'h2,
		IMFLR_ALIGN_RSVD = 2'h3
	} imflr_align_t;
endpackage

// [rtl/imflr_bank.sv]
// imflr_bank: interrupt mask, byte order probe, fifo level thresholds and receive configuration registers
`timescale 1ns/1ps

//Contract
// - a status source reaches the interrupt line only when its mask bit is one
// - status bits keep following their sources regardless of the mask
// - mask bits 31, 25, 24, 23 are read/write, reset zero
// - mask bits 21, 20, 19 are read/write, reset zero
// - mask bits 18, 17, 16 are read/write, reset zero
// - mask bits 15, 14, 13 are read/write, reset zero
// - mask bits 10, 9, 8, 7 enable tx fifo interrupts
// - mask bits 6, 4, 3 and 2-0 enable rx and pin interrupts
// - offset 64h always reads 87654321h
// - tx space flag when free 64-byte blocks exceed bits 31-24, reset 48h
// - tx status level flag when used dwords exceed bits 23-16
// - rx status level flag when used dwords exceed bits 7-0
// - bits 31:30 choose receive end padding boundary 4, 16, 32 bytes
// - 12-bit dword count decrements per rx data read, flags when drained
// - new count may be written any time and counting resumes from it
// - self-clearing bit 15 flushes rx data and status pointers
// - bits 12-8 shift receive data start by 0-31 bytes
// - upper offset bits apply from the next dword read
// - receive dma status bit 20 sets when the count drains; the bank only pulses rx_dma_done_o, bit 20 comes in on interrupt_flags_i
module imflr_bank (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// interrupt status from the controller
	input wire logic [31:0] interrupt_flags_i,
	output logic irq_o,
	// fifo fill levels
	input wire logic [7:0] tx_free_blocks_i,
	input wire logic [7:0] tx_status_used_i,
	input wire logic [7:0] rx_status_used_i,
	output logic tx_space_available_flag_o,
	output logic tx_status_level_flag_o,
	output logic rx_status_level_flag_o,
	// receive data fifo reads
	input wire logic rx_dword_read_i,
	output logic rx_dma_done_o,
	output logic rx_flush_o,
	// receive configuration outputs
	output imflr_pkg::imflr_align_t rx_end_align_o,
	output logic [4:0] receive_start_offset_o
);
	import imflr_pkg::*;

	typedef struct packed {
		// host-visible register fields
		logic [31:0] mask;
		logic [7:0] txavail_lvl;
		logic [7:0] txslvl_lvl;
		logic [7:0] rxslvl_lvl;
		logic [1:0] align;
		logic [11:0] count;
		logic [4:0] offset;
		// offset applied to the receive path
		logic [4:0] offset_live;
		// registered outputs
		logic [31:0] rdata;
		logic irq;
		logic txavail;
		logic txslvl;
		logic rxslvl;
		logic dma_done;
		logic flush;
	} imflr_state_t;

	imflr_state_t s_q;
	imflr_state_t s_d;

	// true when the bus address selects the given register
	function automatic logic imflr_hit(
		input logic [7:0] addr,
		input logic [7:0] off
	);
		imflr_hit = (addr == off);
	endfunction

	// place an 8-bit field at its bit position within a word
	function automatic logic [31:0] imflr_put8(
		input logic [7:0] v,
		input int lsb
	);
		imflr_put8 = 32'(v) << lsb;
	endfunction

	// pick an 8-bit threshold field out of a written word
	function automatic logic [7:0] imflr_get8(
		input logic [31:0] w,
		input int lsb
	);
		imflr_get8 = w[lsb +: 8];
	endfunction

	// writable enables only, so reserved positions stay zero
	function automatic logic [31:0] imflr_mask_next(
		input logic [31:0] wdata
	);
		imflr_mask_next = wdata & IMFLR_MASK_WMASK;
	endfunction

	// strict greater-than: a fill equal to the threshold stays quiet
	function automatic logic imflr_above(
		input logic [7:0] fill,
		input logic [7:0] limit
	);
		imflr_above = (fill > limit);
	endfunction

	// fifo level thresholds as read back; the middle byte stays zero
	function automatic logic [31:0] imflr_level_word(
		input logic [7:0] txavail,
		input logic [7:0] txslvl,
		input logic [7:0] rxslvl
	);
		logic [31:0] w;
		w = 32'h00000000;
		w = w | imflr_put8(txavail, IMFLR_TXAVAIL_LSB);
		w = w | imflr_put8(txslvl, IMFLR_TXSLVL_LSB);
		w = w | imflr_put8(rxslvl, IMFLR_RXSLVL_LSB);
		imflr_level_word = w;
	endfunction

	// receive configuration as read back; the flush bit always reads zero
	function automatic logic [31:0] imflr_rxcfg_word(
		input logic [1:0] align,
		input logic [11:0] count,
		input logic [4:0] offset
	);
		logic [31:0] w;
		w = 32'h00000000;
		w = w | (32'(align) << IMFLR_ALIGN_LSB);
		w = w | (32'(count) << IMFLR_COUNT_LSB);
		w = w | (32'(offset) << IMFLR_OFFSET_LSB);
		imflr_rxcfg_word = w;
	endfunction

	// end alignment field of a written receive configuration word
	function automatic logic [1:0] imflr_align_of(
		input logic [31:0] w
	);
		imflr_align_of = w[IMFLR_ALIGN_LSB +: 2];
	endfunction

	// dword count field of a written receive configuration word
	function automatic logic [11:0] imflr_count_of(
		input logic [31:0] w
	);
		imflr_count_of = w[IMFLR_COUNT_LSB +: 12];
	endfunction

	// byte offset field of a written receive configuration word
	function automatic logic [4:0] imflr_offset_of(
		input logic [31:0] w
	);
		imflr_offset_of = w[IMFLR_OFFSET_LSB +: 5];
	endfunction

	// countdown step: one less per dword read, never below zero
	function automatic logic [11:0] imflr_count_step(
		input logic [11:0] count,
		input logic rd
	);
		if (rd && (count != IMFLR_COUNT_ZERO)) begin
			imflr_count_step = count - IMFLR_COUNT_ONE;
		end else begin
			imflr_count_step = count;
		end
	endfunction

	// true on the read that drains the last programmed dword
	function automatic logic imflr_count_last(
		input logic [11:0] count,
		input logic rd
	);
		imflr_count_last = rd && (count == IMFLR_COUNT_ONE);
	endfunction

	// dword part moves at a dword read, byte part follows at once
	function automatic logic [4:0] imflr_offset_next(
		input logic [4:0] live,
		input logic [4:0] prog,
		input logic rd
	);
		logic [4:0] n;
		n = live;
		if (rd) begin
			n[4:2] = prog[4:2];
		end
		n[1:0] = prog[1:0];
		imflr_offset_next = n;
	endfunction

	// any enabled status source raises the host line
	function automatic logic imflr_irq(
		input logic [31:0] flags,
		input logic [31:0] mask
	);
		imflr_irq = |(flags & mask);
	endfunction

	// next state of the whole bank
	always_comb begin
		logic wr_mask;
		logic wr_level;
		logic wr_rx;
		logic cnt_last;
		// defaults before decode
		wr_mask = 1'b0;
		wr_level = 1'b0;
		wr_rx = 1'b0;
		cnt_last = 1'b0;

		// register strobes decoded once per cycle
		wr_mask = reg_wr_i && imflr_hit(reg_addr_i, IMFLR_OFF_MASK);
		wr_level = reg_wr_i && imflr_hit(reg_addr_i, IMFLR_OFF_LEVEL);
		wr_rx = reg_wr_i && imflr_hit(reg_addr_i, IMFLR_OFF_RXCFG);
		cnt_last = imflr_count_last(s_q.count, rx_dword_read_i);

		// hold every field; pulses and read data fall back to zero
		s_d = s_q;
		s_d.flush = 1'b0;
		s_d.dma_done = 1'b0;
		s_d.rdata = 32'h00000000;

		// interrupt mask register writes
		if (wr_mask) begin
			s_d.mask = imflr_mask_next(reg_wdata_i);
		end else begin
			s_d.mask = s_q.mask;
		end

		// fifo level threshold writes; the middle byte is dropped
		if (wr_level) begin
			s_d.txavail_lvl = imflr_get8(reg_wdata_i, IMFLR_TXAVAIL_LSB);
			s_d.txslvl_lvl = imflr_get8(reg_wdata_i, IMFLR_TXSLVL_LSB);
			s_d.rxslvl_lvl = imflr_get8(reg_wdata_i, IMFLR_RXSLVL_LSB);
		end else begin
			s_d.txavail_lvl = s_q.txavail_lvl;
			s_d.txslvl_lvl = s_q.txslvl_lvl;
			s_d.rxslvl_lvl = s_q.rxslvl_lvl;
		end

		// receive dword countdown; a host write wins over a read in the same cycle
		if (wr_rx) begin
			s_d.count = imflr_count_of(reg_wdata_i);
		end else begin
			s_d.count = imflr_count_step(s_q.count, rx_dword_read_i);
		end

		// done pulse only when the drain is not overtaken by a reload
		if (cnt_last && !wr_rx) begin
			s_d.dma_done = 1'b1;
		end else begin
			s_d.dma_done = 1'b0;
		end

		// end alignment, taken as written; the host keeps it steady within a packet
		if (wr_rx) begin
			s_d.align = imflr_align_of(reg_wdata_i);
		end else begin
			s_d.align = s_q.align;
		end

		// programmed data offset
		if (wr_rx) begin
			s_d.offset = imflr_offset_of(reg_wdata_i);
		end else begin
			s_d.offset = s_q.offset;
		end

		// self-clearing flush: a one-cycle pulse, never stored as a readable bit
		if (wr_rx) begin
			s_d.flush = reg_wdata_i[IMFLR_FLUSH_BIT];
		end else begin
			s_d.flush = 1'b0;
		end

		// offset seen by the receive path
		s_d.offset_live = imflr_offset_next(s_q.offset_live, s_q.offset, rx_dword_read_i);

		// fifo level comparisons, registered one cycle late
		s_d.txavail = imflr_above(tx_free_blocks_i, s_q.txavail_lvl);
		s_d.txslvl = imflr_above(tx_status_used_i, s_q.txslvl_lvl);
		s_d.rxslvl = imflr_above(rx_status_used_i, s_q.rxslvl_lvl);

		// masked interrupt; raw flags pass by untouched
		s_d.irq = imflr_irq(interrupt_flags_i, s_q.mask);

		// read data, valid only the cycle after the strobe
		if (reg_rd_i) begin
			case (reg_addr_i)
				IMFLR_OFF_MASK: begin
					s_d.rdata = s_q.mask;
				end
				IMFLR_OFF_PROBE: begin
					s_d.rdata = IMFLR_PROBE_VALUE;
				end
				IMFLR_OFF_LEVEL: begin
					s_d.rdata = imflr_level_word(s_q.txavail_lvl, s_q.txslvl_lvl, s_q.rxslvl_lvl);
				end
				IMFLR_OFF_RXCFG: begin
					s_d.rdata = imflr_rxcfg_word(s_q.align, s_q.count, s_q.offset);
				end
				default: begin
					s_d.rdata = 32'h00000000;
				end
			endcase
		end else begin
			s_d.rdata = 32'h00000000;
		end
	end

	// state register
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			// host-visible fields
			s_q.mask <= 32'h00000000;
			s_q.txavail_lvl <= IMFLR_TXAVAIL_RST;
			s_q.txslvl_lvl <= IMFLR_TXSLVL_RST;
			s_q.rxslvl_lvl <= IMFLR_RXSLVL_RST;
			s_q.align <= IMFLR_ALIGN_RST;
			s_q.count <= IMFLR_COUNT_RST;
			s_q.offset <= IMFLR_OFFSET_RST;
			s_q.offset_live <= IMFLR_OFFSET_RST;
			// registered outputs
			s_q.rdata <= 32'h00000000;
			s_q.irq <= 1'b0;
			s_q.txavail <= 1'b0;
			s_q.txslvl <= 1'b0;
			s_q.rxslvl <= 1'b0;
			s_q.dma_done <= 1'b0;
			s_q.flush <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// register port read data, straight from its flip-flops
	assign reg_rdata_o = s_q.rdata;

	// host interrupt line
	assign irq_o = s_q.irq;

	// fifo level flags
	assign tx_space_available_flag_o = s_q.txavail;
	assign tx_status_level_flag_o = s_q.txslvl;
	assign rx_status_level_flag_o = s_q.rxslvl;

	// countdown and flush pulses
	assign rx_dma_done_o = s_q.dma_done;
	assign rx_flush_o = s_q.flush;

	// receive configuration seen by the receive path
	assign rx_end_align_o = imflr_align_t'(s_q.align);
	assign receive_start_offset_o = s_q.offset_live;
endmodule // imflr_bank

// [test/imflr_chk.sv]
// imflr_chk: port assertions of the register bank
`timescale 1ns/1ps
module imflr_chk (
	input wire logic clk_sys_i, rst_i, reg_wr_i, reg_rd_i, irq_o, rx_dword_read_i, rx_dma_done_o, rx_flush_o,
	input wire logic tx_space_available_flag_o,
	input wire logic [7:0] reg_addr_i, tx_free_blocks_i,
	input wire logic [31:0] reg_wdata_i, reg_rdata_o, interrupt_flags_i,
	input wire logic [4:0] receive_start_offset_o,
	input wire imflr_pkg::imflr_align_t rx_end_align_o
);
	import imflr_pkg::*;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// probe read and rx config write
	sequence probe_rd_s; reg_rd_i && reg_addr_i == 8'h64; endsequence
	sequence cfg_wr_s; reg_wr_i && reg_addr_i == 8'h6c; endsequence
	probe_read_a: assert property (probe_rd_s |=> reg_rdata_o == 32'h87654321) else $error("bad probe");
	irq_quiet_a: assert property (interrupt_flags_i == 32'h0 |=> !irq_o) else $error("stray irq");
	space_zero_a: assert property (tx_free_blocks_i == 8'h00 |=> !tx_space_available_flag_o) else $error("bad space");
	flush_start_a: assert property (cfg_wr_s ##0 reg_wdata_i[15] |=> rx_flush_o) else $error("no flush");
	flush_cause_a: assert property (rx_flush_o |-> $past(reg_wr_i && reg_addr_i == 8'h6c && reg_wdata_i[15]))
		else $error("stray flush");
	done_pulse_a: assert property (rx_dma_done_o |-> $past(rx_dword_read_i) ##1 !rx_dma_done_o)
		else $error("bad done");
	offset_step_a: assert property ($changed(receive_start_offset_o[4:2]) |-> $past(rx_dword_read_i))
		else $error("offset moved");
	align_cause_a: assert property ($changed(rx_end_align_o) |-> $past(reg_wr_i && reg_addr_i == 8'h6c))
		else $error("align moved");
endmodule // imflr_chk

// [test/imflr_host.sv]
// imflr_host: host model on the register port
`timescale 1ns/1ps
module imflr_host (
	input wire logic clk_sys_i,
	input wire logic [31:0] rdata_i,
	output logic [7:0] addr_o = 8'h00,
	output logic [31:0] wdata_o = 32'h0,
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0
);
	// one-cycle write; alignment and low offset bits only changed between packets
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i) {wr_o, addr_o, wdata_o} <= {1'b1, a, d};
		@(posedge clk_sys_i) {wr_o, wdata_o} <= {1'b0, ~d};
	endtask
	// one-cycle read, data taken in the cycle after
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_i) {rd_o, addr_o} <= {1'b1, a};
		@(posedge clk_sys_i) rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask
endmodule // imflr_host

// [test/irq_mask_fifo_level_rx_cfg_tb.sv]
// irq_mask_fifo_level_rx_cfg_tb: self-checking bench of the register bank
`timescale 1ns/1ps
module irq_mask_fifo_level_rx_cfg_tb;
	import imflr_pkg::*;
	logic clk_sys_i = 1'b0, rst_i = 1'b1, rx_dword_read_i = 1'b0, reg_wr_i, reg_rd_i, irq_o, rx_dma_done_o, rx_flush_o;
	logic tx_space_available_flag_o, tx_status_level_flag_o, rx_status_level_flag_o;
	logic [7:0] reg_addr_i, tx_free_blocks_i = 8'h00, tx_status_used_i = 8'h00, rx_status_used_i = 8'h00;
	logic [31:0] reg_wdata_i, reg_rdata_o, d, interrupt_flags_i = 32'h0;
	logic [4:0] receive_start_offset_o;
	imflr_align_t rx_end_align_o;
	int error_cnt = 0, checked = 0;
	wire [2:0] lvl = {tx_space_available_flag_o, tx_status_level_flag_o, rx_status_level_flag_o};
	initial forever #2.5 clk_sys_i = ~clk_sys_i;
	imflr_host u_imflr_host (.clk_sys_i(clk_sys_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
		.wr_o(reg_wr_i), .rd_o(reg_rd_i));
	imflr_bank u_imflr_bank (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .interrupt_flags_i(interrupt_flags_i),
		.irq_o(irq_o), .tx_free_blocks_i(tx_free_blocks_i), .tx_status_used_i(tx_status_used_i),
		.rx_status_used_i(rx_status_used_i), .tx_space_available_flag_o(tx_space_available_flag_o),
		.tx_status_level_flag_o(tx_status_level_flag_o), .rx_status_level_flag_o(rx_status_level_flag_o),
		.rx_dword_read_i(rx_dword_read_i), .rx_dma_done_o(rx_dma_done_o), .rx_flush_o(rx_flush_o),
		.rx_end_align_o(rx_end_align_o), .receive_start_offset_o(receive_start_offset_o));
	// compare and count
	task automatic chk(input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// read a register and compare
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		u_imflr_host.rd(a, d);
		chk(d, exp);
	endtask
	// drive flags and fill levels, settle one cycle
	task automatic tick(input logic [31:0] f, input logic [23:0] lv);
		@(posedge clk_sys_i) {interrupt_flags_i, tx_free_blocks_i, tx_status_used_i, rx_status_used_i} <= {f, lv};
		@(posedge clk_sys_i) #1;
	endtask
	// one dword read from the rx data fifo
	task automatic pulse();
		@(posedge clk_sys_i) rx_dword_read_i <= 1'b1;
		@(posedge clk_sys_i) rx_dword_read_i <= 1'b0;
		#1;
	endtask
	task automatic t_regs();
		rdc(8'h5c, 32'h0);
		rdc(8'h68, 32'h48000000);
		u_imflr_host.wr(8'h5c, 32'hffffffff);
		rdc(8'h5c, 32'h83bfe7df);
		u_imflr_host.wr(8'h64, 32'h0);
		rdc(8'h64, 32'h87654321);
		rdc(8'h60, 32'h0);
	endtask
	task automatic t_irq();
		tick(32'h00400000, 24'h0);
		chk(irq_o, 1'b0);
		tick(32'h00100000, 24'h0);
		chk(irq_o, 1'b1);
		u_imflr_host.wr(8'h5c, 32'hffefffff);
		tick(32'h00100000, 24'h0);
		chk(irq_o, 1'b0);
	endtask
	task automatic t_level();
		u_imflr_host.wr(8'h68, 32'h10050003);
		tick(32'h0, 24'h110504);
		chk(lvl, 3'b101);
		tick(32'h0, 24'h100603);
		chk(lvl, 3'b010);
	endtask
	task automatic t_count();
		u_imflr_host.wr(8'h6c, 32'h40031f00);
		tick(32'h0, 24'h0);
		chk({rx_end_align_o, receive_start_offset_o}, 7'h23);
		pulse();
		chk({rx_dma_done_o, receive_start_offset_o}, 6'h1f);
		u_imflr_host.wr(8'h6c, 32'h80011f00);
		pulse();
		chk({rx_dma_done_o, rx_end_align_o}, 3'b110);
		pulse();
		chk(rx_dma_done_o, 1'b0);
	endtask
	task automatic t_flush();
		u_imflr_host.wr(8'h6c, 32'hffffffff);
		#1 chk(rx_flush_o, 1'b1);
		rdc(8'h6c, 32'hcfff1f00);
	endtask
	// reset in mid-run brings back the register reset values and zero irq, flush, done and offset outputs
	task automatic t_reset();
		@(posedge clk_sys_i) rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rdc(8'h5c, 32'h0);
		rdc(8'h68, 32'h48000000);
		rdc(8'h6c, 32'h0);
		chk({irq_o, rx_flush_o, rx_dma_done_o, receive_start_offset_o}, 8'h00);
	endtask
	// verdict and end of run
	task automatic print_verdict();
		if (error_cnt == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		t_regs();
		t_irq();
		t_level();
		t_count();
		t_flush();
		t_reset();
		print_verdict();
	end
	// watchdog
	initial begin
		#5000;
		error_cnt++;
		print_verdict();
	end
endmodule // irq_mask_fifo_level_rx_cfg_tb
bind imflr_bank imflr_chk u_imflr_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.irq_o(irq_o), .rx_dword_read_i(rx_dword_read_i), .rx_dma_done_o(rx_dma_done_o), .rx_flush_o(rx_flush_o),
	.tx_space_available_flag_o(tx_space_available_flag_o), .reg_addr_i(reg_addr_i),
	.tx_free_blocks_i(tx_free_blocks_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.interrupt_flags_i(interrupt_flags_i), .receive_start_offset_o(receive_start_offset_o),
	.rx_end_align_o(rx_end_align_o));
